/* File: logic/zaa_consts.svh */
// Offsets, bit positions, reset values and timing counts of the annunciator.
// Assumes a 200 MHz clock; included by bare name, guarded against reuse.
`ifndef ZAA_CONSTS_SVH
`define ZAA_CONSTS_SVH
`define ZAA_ZONES 8
`define ZAA_DB_BITS 13
`define ZAA_CNT_W 20
`define ZAA_IN_ACK 8
`define ZAA_IN_CLR 9
`define ZAA_IN_SDIS 10
`define ZAA_IN_SMEM 11
`define ZAA_IN_MKEY 12
`define ZAA_RST_ARMED 8'hFF
`define ZAA_CLK_NS 5
`define ZAA_DEBOUNCE_NS 5000000
`endif

/* File: logic/zaa_pkg.sv */
// Types shared by the annunciator modules.
// Assumes zaa_consts.svh is on the include path.
`include "zaa_consts.svh"
package zaa_pkg;
   // Common output behaviour; every code is a legal mode
   typedef enum logic [1:0] {
      ZAA_CM_NONLATCH = 2'h0,
      ZAA_CM_LATCH = 2'h1,
      ZAA_CM_AUDIBLE = 2'h2,
      ZAA_CM_SHUNT = 2'h3
   } zaa_cmode_t;
   typedef struct packed {
      logic [`ZAA_ZONES-1:0] alarm;
      logic [`ZAA_ZONES-1:0] trouble;
      logic [`ZAA_ZONES-1:0] tamper;
   } zaa_zone_in_t;
   typedef struct packed {
      logic [`ZAA_ZONES-1:0] zone_24h;
      logic [`ZAA_ZONES-1:0] ind_latch;
      logic snd_silence;
      zaa_cmode_t [1:0] com_mode;
   } zaa_cfg_t;
   typedef struct packed {
      logic valid;
      logic [2:0] zone;
      logic disarm;
   } zaa_rcmd_t;
   typedef struct packed {
      logic [`ZAA_DB_BITS-1:0] sync1;
      logic [`ZAA_DB_BITS-1:0] sync2;
      logic [`ZAA_DB_BITS-1:0] stab_n;
      logic [`ZAA_DB_BITS-1:0] press;
      logic [`ZAA_DB_BITS-1:0][`ZAA_CNT_W-1:0] cnt;
   } zaa_db_state_t;
   typedef struct packed {
      logic [`ZAA_ZONES-1:0] armed;
      logic [`ZAA_ZONES-1:0] alm_lat;
      logic [`ZAA_ZONES-1:0] ack;
      logic [`ZAA_ZONES-1:0] fault_prev;
      logic [`ZAA_ZONES-1:0] shunt_led;
      logic [`ZAA_ZONES-1:0] trouble_led;
      logic [`ZAA_ZONES-1:0] ind_out;
      logic [1:0] com_out;
      logic sounder;
   } zaa_top_state_t;
endpackage : zaa_pkg

/* File: logic/zaa_debounce.sv */
// Synchroniser and debouncer for the active-low switch inputs.
// Assumes open inputs read high through pull-ups; one clock domain.
`timescale 1ns/10ps
`include "zaa_consts.svh"
module zaa_debounce #(
   parameter logic [`ZAA_CNT_W-1:0] DB_CYCLES = 20'hF4240
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`ZAA_DB_BITS-1:0] raw_n,
   output logic [`ZAA_DB_BITS-1:0] level,
   output logic [`ZAA_DB_BITS-1:0] press
);
   zaa_pkg::zaa_db_state_t st_q;
   zaa_pkg::zaa_db_state_t st_d;
   // sync then debounce
   // A level must stand for DB_CYCLES before it is believed; sync1 feeds
   // only sync2 so a metastable first stage never reaches the counter.
   always_comb begin
      st_d = st_q;
      st_d.sync1 = raw_n;
      st_d.sync2 = st_q.sync1;
      st_d.press = '0;
      for (int i = 0; i < `ZAA_DB_BITS; i++) begin
         if (st_q.sync2[i] == st_q.stab_n[i]) begin
            st_d.cnt[i] = '0;
         end else if (st_q.cnt[i] >= DB_CYCLES - 20'h1) begin
            st_d.cnt[i] = '0;
            st_d.stab_n[i] = st_q.sync2[i];
            st_d.press[i] = ~st_q.sync2[i];
         end else begin
            st_d.cnt[i] = st_q.cnt[i] + 20'h1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '{sync1: '1, sync2: '1, stab_n: '1, press: '0, cnt: '0};
      end else begin
         st_q <= st_d;
      end
   end
   assign level = ~st_q.stab_n;
   assign press = st_q.press;
endmodule : zaa_debounce

/* File: logic/zaa_common_out.sv */
// Mode selector for one common output.
// Assumes summary terms already reflect the next registered state.
`timescale 1ns/10ps
module zaa_common_out (
   input zaa_pkg::zaa_cmode_t mode,
   input wire logic any_fault,
   input wire logic any_latched,
   input wire logic any_unacked,
   input wire logic any_shunt,
   output logic out
);
   // Pure decode; the top registers the result
   always_comb begin
      unique case (mode)
         zaa_pkg::ZAA_CM_NONLATCH: out = any_fault;
         zaa_pkg::ZAA_CM_LATCH: out = any_latched;
         zaa_pkg::ZAA_CM_AUDIBLE: out = any_unacked;
         zaa_pkg::ZAA_CM_SHUNT: out = any_shunt;
      endcase
   end
endmodule : zaa_common_out

/* File: logic/zaa_top.sv */
// Eight-zone alarm annunciator: arm state, latching, sounder and outputs.
// Assumes zone conditions arrive already decoded and synchronous to clk;
// switch inputs are raw, active low, and are debounced here.
`timescale 1ns/10ps
`include "zaa_consts.svh"
module zaa_top #(
   parameter logic [`ZAA_CNT_W-1:0] DB_CYCLES =
      `ZAA_CNT_W'((`ZAA_DEBOUNCE_NS + `ZAA_CLK_NS - 1) / `ZAA_CLK_NS)
) (
   input wire logic clk,
   input wire logic rst_n,
   input zaa_pkg::zaa_zone_in_t zin,
   input wire logic [`ZAA_ZONES-1:0] zone_btn_n,
   input wire logic ack_n,
   input wire logic clear_n,
   input wire logic key_shunt_dis_n,
   input wire logic key_shunt_mem_n,
   input wire logic master_key_n,
   input zaa_pkg::zaa_cfg_t cfg,
   input zaa_pkg::zaa_rcmd_t rcmd,
   output logic [`ZAA_ZONES-1:0] shunt_led,
   output logic [`ZAA_ZONES-1:0] alarm_led,
   output logic [`ZAA_ZONES-1:0] trouble_led,
   output logic [`ZAA_ZONES-1:0] ind_out,
   output logic [1:0] com_out,
   output logic sounder
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   zaa_pkg::zaa_top_state_t st_q;
   zaa_pkg::zaa_top_state_t st_d;
   logic [`ZAA_DB_BITS-1:0] db_level;
   logic [`ZAA_DB_BITS-1:0] db_press;
   logic master_on_w;
   logic ack_p_w;
   logic clr_p_w;
   logic sdis_w;
   logic smem_w;
   logic [`ZAA_ZONES-1:0] fault_w;
   logic [`ZAA_ZONES-1:0] pb_w;
   logic [`ZAA_ZONES-1:0] lat_nx_w;
   logic [`ZAA_ZONES-1:0] ack_nx_w;
   logic [`ZAA_ZONES-1:0] arm_nx_w;
   logic [`ZAA_ZONES-1:0] shunt_nx_w;
   logic [1:0] com_w;

   // ----------------------------------------------------------------
   // Switch conditioning
   // ----------------------------------------------------------------
   // debounce all switches
   zaa_debounce #(
      .DB_CYCLES(DB_CYCLES)
   ) u_db (
      .clk(clk),
      .rst_n(rst_n),
      .raw_n({master_key_n, key_shunt_mem_n, key_shunt_dis_n, clear_n,
              ack_n, zone_btn_n}),
      .level(db_level),
      .press(db_press)
   );

   // Debounced levels and one-cycle press pulses
   assign master_on_w = db_level[`ZAA_IN_MKEY];
   assign ack_p_w = db_press[`ZAA_IN_ACK];
   assign clr_p_w = db_press[`ZAA_IN_CLR];
   assign sdis_w = db_level[`ZAA_IN_SDIS];
   assign smem_w = db_level[`ZAA_IN_SMEM];
   assign pb_w = master_on_w ? '0 : db_press[`ZAA_ZONES-1:0];

   // ----------------------------------------------------------------
   // Per-zone next state
   // ----------------------------------------------------------------
   // One slice per zone; each slice sees only its own bits plus the
   // shared keys, so zones never interfere with one another.
   for (genvar i = 0; i < `ZAA_ZONES; i++) begin : g_zone
      logic eff_armed;
      logic zack;
      logic zrst;
      logic tog;
      logic rsel;
      logic rise;
      assign eff_armed = cfg.zone_24h[i] | (master_on_w & st_q.armed[i]);
      assign fault_w[i] = (zin.alarm[i] & eff_armed) | zin.trouble[i] |
                          zin.tamper[i];
      assign rise = fault_w[i] & ~st_q.fault_prev[i];
      // Button acts as acknowledge, then reset, then bypass toggle
      assign zack = ack_p_w | (pb_w[i] & st_q.alm_lat[i] & ~st_q.ack[i]);
      assign zrst = clr_p_w | (pb_w[i] & st_q.alm_lat[i] & st_q.ack[i]);
      assign tog = pb_w[i] & ~st_q.alm_lat[i];
      assign rsel = rcmd.valid & (rcmd.zone == 3'(i));
      // fault sets, reset clears
      // Set wins: a reset while still faulted leaves the latch on
      assign lat_nx_w[i] = fault_w[i] | (st_q.alm_lat[i] & ~zrst);
      assign ack_nx_w[i] = rise ? 1'b0 :
                           (lat_nx_w[i] & (st_q.ack[i] |
                           (zack & st_q.alm_lat[i])));
      // Arm state: 24-hour first, then freeze key, then remote, then button
      always_comb begin
         if (cfg.zone_24h[i]) begin
            arm_nx_w[i] = 1'b1;
         end else if (smem_w) begin
            arm_nx_w[i] = st_q.armed[i];
         end else if (rsel) begin
            arm_nx_w[i] = ~rcmd.disarm;
         end else if (tog && !(st_q.armed[i] && sdis_w)) begin
            arm_nx_w[i] = ~st_q.armed[i];
         end else begin
            arm_nx_w[i] = st_q.armed[i];
         end
      end
      assign shunt_nx_w[i] = ~arm_nx_w[i];
   end

   // ----------------------------------------------------------------
   // Common outputs
   // ----------------------------------------------------------------
   // Summaries are taken from next state so outputs line up with it
   for (genvar c = 0; c < 2; c++) begin : g_com
      zaa_common_out u_com (
         .mode(cfg.com_mode[c]),
         .any_fault(|fault_w),
         .any_latched(|lat_nx_w),
         .any_unacked(|(lat_nx_w & ~ack_nx_w)),
         .any_shunt(|shunt_nx_w),
         .out(com_w[c])
      );
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Assemble next state; every output is a field of it
   always_comb begin
      st_d = st_q;
      st_d.armed = arm_nx_w;
      st_d.alm_lat = lat_nx_w;
      st_d.ack = ack_nx_w;
      st_d.fault_prev = fault_w;
      st_d.shunt_led = shunt_nx_w;
      st_d.trouble_led = zin.trouble | zin.tamper;
      st_d.ind_out = (cfg.ind_latch & lat_nx_w) | (~cfg.ind_latch & fault_w);
      st_d.com_out = com_w;
      st_d.sounder = cfg.snd_silence ? |(lat_nx_w & ~ack_nx_w) : |lat_nx_w;
   end

   // Zones start armed with nothing latched
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '{armed: `ZAA_RST_ARMED, shunt_led: ~`ZAA_RST_ARMED,
                   default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign shunt_led = st_q.shunt_led;
   assign alarm_led = st_q.alm_lat;
   assign trouble_led = st_q.trouble_led;
   assign ind_out = st_q.ind_out;
   assign com_out = st_q.com_out;
   assign sounder = st_q.sounder;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Helper: first cycle after reset has no meaningful past inputs
   logic ast_run_q;
   logic [`ZAA_ZONES-1:0] ast_pbk_w;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ast_run_q <= 1'b0;
      end else begin
         ast_run_q <= 1'b1;
      end
   end
   assign ast_pbk_w = pb_w & st_q.alm_lat & ~st_q.ack &
                      ~(fault_w & ~st_q.fault_prev);

   AST_NONSIL_HOLD: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && !$past(cfg.snd_silence) && (st_q.alm_lat != 8'h00)
      |-> sounder)
      else $error("sounder quiet while a zone is latched");
   AST_SIL_ACK: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.snd_silence) &&
      ((st_q.alm_lat & ~st_q.ack) == 8'h00) |-> !sounder)
      else $error("sounder on with every alarm acknowledged");
   AST_RESOUND: assert property (@(posedge clk)
      disable iff (!rst_n)
      ((fault_w & ~st_q.fault_prev) != 8'h00) |=> sounder)
      else $error("new alarm did not sound");
   AST_SDIS_NODISARM: assert property (@(posedge clk)
      disable iff (!rst_n)
      sdis_w && !rcmd.valid
      |=> ((~st_q.armed & $past(st_q.armed)) == 8'h00))
      else $error("button disarmed a zone under shunt disable");
   AST_MEM_FREEZE: assert property (@(posedge clk)
      disable iff (!rst_n)
      smem_w |=> (st_q.armed == ($past(st_q.armed) | $past(cfg.zone_24h))))
      else $error("arm state moved under memory key");
   AST_SHUNT_LAMP: assert property (@(posedge clk)
      disable iff (!rst_n)
      shunt_led == ~st_q.armed)
      else $error("shunt lamp disagrees with arm state");
   AST_IND_LATCH: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q |-> (((ind_out ^ st_q.alm_lat) & $past(cfg.ind_latch))
      == 8'h00))
      else $error("latched zone output not tracking latch");
   AST_IND_LIVE: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q |-> (((ind_out ^ $past(fault_w)) & ~$past(cfg.ind_latch))
      == 8'h00))
      else $error("live zone output not tracking fault");
   AST_COM_LATCH: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[0]) == zaa_pkg::ZAA_CM_LATCH
      |-> com_out[0] == (st_q.alm_lat != 8'h00))
      else $error("latched common output wrong");
   AST_COM_LIVE: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[0]) == zaa_pkg::ZAA_CM_NONLATCH
      |-> com_out[0] == $past(fault_w != 8'h00))
      else $error("live common output wrong");
   AST_COM_AUDIBLE: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[1]) == zaa_pkg::ZAA_CM_AUDIBLE
      |-> com_out[1] == ((st_q.alm_lat & ~st_q.ack) != 8'h00))
      else $error("audible common output wrong");
   AST_COM_SHUNT: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[1]) == zaa_pkg::ZAA_CM_SHUNT
      |-> com_out[1] == (shunt_led != 8'h00))
      else $error("shunt common output wrong");
   AST_24H_ARMED: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q |-> ((~st_q.armed & $past(cfg.zone_24h)) == 8'h00))
      else $error("24-hour zone found disarmed");
   AST_MASTER_OFF: assert property (@(posedge clk)
      disable iff (!rst_n)
      !master_on_w |-> ((fault_w & ~cfg.zone_24h) ==
      ((zin.trouble | zin.tamper) & ~cfg.zone_24h)))
      else $error("alarm answered while master disarmed");
   AST_BTN_ACK: assert property (@(posedge clk)
      disable iff (!rst_n)
      !master_on_w && !clr_p_w && (ast_pbk_w != 8'h00)
      |=> ((st_q.ack & $past(ast_pbk_w)) == $past(ast_pbk_w)))
      else $error("zone button failed to acknowledge");
   AST_MASTER_ON: assert property (@(posedge clk)
      disable iff (!rst_n)
      master_on_w |-> ((~fault_w & zin.alarm & st_q.armed) == 8'h00))
      else $error("armed zone alarm not answered");
   AST_BTN_DEAD: assert property (@(posedge clk)
      disable iff (!rst_n)
      master_on_w && !ack_p_w |=> ((st_q.ack & ~$past(st_q.ack)) == 8'h00))
      else $error("zone button acted while master armed");
   AST_REMOTE: assert property (@(posedge clk)
      disable iff (!rst_n)
      rcmd.valid && !smem_w && !cfg.zone_24h[rcmd.zone]
      |=> st_q.armed[$past(rcmd.zone)] == !$past(rcmd.disarm))
      else $error("remote shunt command not applied");
   AST_COM1_LATCH: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[1]) == zaa_pkg::ZAA_CM_LATCH
      |-> com_out[1] == (st_q.alm_lat != 8'h00))
      else $error("latched common output 1 wrong");
   AST_COM1_LIVE: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[1]) == zaa_pkg::ZAA_CM_NONLATCH
      |-> com_out[1] == $past(fault_w != 8'h00))
      else $error("live common output 1 wrong");
   AST_COM0_AUDIBLE: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[0]) == zaa_pkg::ZAA_CM_AUDIBLE
      |-> com_out[0] == ((st_q.alm_lat & ~st_q.ack) != 8'h00))
      else $error("audible common output 0 wrong");
   AST_COM0_SHUNT: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q && $past(cfg.com_mode[0]) == zaa_pkg::ZAA_CM_SHUNT
      |-> com_out[0] == (shunt_led != 8'h00))
      else $error("shunt common output 0 wrong");
   AST_TRB_REPORT: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q |-> trouble_led == $past(zin.trouble | zin.tamper))
      else $error("trouble or tamper not reported");
   // press only on change
   // A press pulse must coincide with a fresh debounced level
   AST_DB_PRESS: assert property (@(posedge clk)
      disable iff (!rst_n)
      ast_run_q |-> ((db_press & ~(db_level & ~$past(db_level)))
      == 13'h0000))
      else $error("switch press without a debounced change");

   // ----------------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------------
   // Main scenarios worth seeing in a run
   COV_BTN_ACK: cover property (@(posedge clk) disable iff (!rst_n)
      !master_on_w && (ast_pbk_w != 8'h00));
   COV_SILENCE: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(sounder) && (st_q.alm_lat != 8'h00));
   COV_RESOUND: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(sounder) && ($past(st_q.ack) != 8'h00));
   COV_BYPASS: cover property (@(posedge clk) disable iff (!rst_n)
      !master_on_w && (pb_w != 8'h00) ##1 $changed(st_q.armed));
   COV_REMOTE: cover property (@(posedge clk) disable iff (!rst_n)
      rcmd.valid && rcmd.disarm ##1 (shunt_led != 8'h00));
endmodule : zaa_top

/* File: tb/zaa_switch_model.sv */
// Far-side model of the panel switches: buttons, keys and control inputs.
// Assumes the bench sets one closed bit per switch; open lines float high.
`timescale 1ns/10ps
`include "zaa_consts.svh"
module zaa_switch_model (
   input wire logic [`ZAA_DB_BITS-1:0] closed,
   output logic [`ZAA_ZONES-1:0] zone_btn_n,
   output logic ack_n,
   output logic clear_n,
   output logic key_shunt_dis_n,
   output logic key_shunt_mem_n,
   output logic master_key_n
);
   // ---------------------------------------------
   // Contact to line mapping
   // ---------------------------------------------
   logic [`ZAA_DB_BITS-1:0] line_n;
   // pull-up, ground closes
   // An open contact reads as the pull-up level, never a stale value
   assign line_n = ~closed;
   assign zone_btn_n = line_n[`ZAA_ZONES-1:0];
   assign ack_n = line_n[`ZAA_IN_ACK];
   assign clear_n = line_n[`ZAA_IN_CLR];
   assign key_shunt_dis_n = line_n[`ZAA_IN_SDIS];
   assign key_shunt_mem_n = line_n[`ZAA_IN_SMEM];
   assign master_key_n = line_n[`ZAA_IN_MKEY];
endmodule : zaa_switch_model

/* File: tb/zaa_testbench.sv */
// Self-checking bench for the annunciator top with a short debounce.
// Assumes the switch model on the raw inputs and zone levels from here.
`timescale 1ns/10ps
`include "zaa_consts.svh"
module testbench;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   zaa_pkg::zaa_zone_in_t zin = '0;
   zaa_pkg::zaa_cfg_t cfg = '0;
   zaa_pkg::zaa_rcmd_t rcmd = '0;
   logic [`ZAA_DB_BITS-1:0] closed = '0;
   logic [`ZAA_ZONES-1:0] btn_n, shunt_led, alarm_led, trouble_led, ind_out;
   logic ack_n, clear_n, sdis_n, smem_n, mkey_n, sounder;
   logic [1:0] com_out;
   int fails = 0;
   int compares = 0;
   // Clock, 5 ns period
   always #2.5 clk = ~clk;
   zaa_switch_model sw_model (.closed(closed), .zone_btn_n(btn_n),
      .ack_n(ack_n), .clear_n(clear_n), .key_shunt_dis_n(sdis_n),
      .key_shunt_mem_n(smem_n), .master_key_n(mkey_n));
   // Short debounce keeps each press near two dozen cycles
   zaa_top #(.DB_CYCLES(20'h00004)) uut (.clk(clk), .rst_n(rst_n),
      .zin(zin), .zone_btn_n(btn_n), .ack_n(ack_n), .clear_n(clear_n),
      .key_shunt_dis_n(sdis_n), .key_shunt_mem_n(smem_n),
      .master_key_n(mkey_n), .cfg(cfg), .rcmd(rcmd),
      .shunt_led(shunt_led), .alarm_led(alarm_led),
      .trouble_led(trouble_led), .ind_out(ind_out), .com_out(com_out),
      .sounder(sounder));
   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic sw(input int idx, input logic v);
      @(posedge clk);
      closed[idx] <= v;
   endtask : sw
   // Held well past the debounce so one press gives one action
   task automatic press(input int idx);
      sw(idx, 1'h1);
      cyc(12);
      sw(idx, 1'h0);
      cyc(12);
   endtask : press
   task automatic remote(input logic [2:0] zone, input logic disarm);
      @(posedge clk);
      rcmd <= '{valid: 1'h1, zone: zone, disarm: disarm};
      @(posedge clk);
      rcmd <= '0;
      cyc(2);
   endtask : remote
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      check(shunt_led, 8'h00);
      check({sounder, com_out, ind_out[0]}, 8'h00);
   endtask : t_reset
   // Master off: trouble still shows, alarm on a normal zone is dropped
   task automatic t_master_off();
      @(posedge clk);
      zin.trouble[2] <= 1'h1;
      cyc(3);
      check(trouble_led[2], 8'h01);
      zin.trouble[2] <= 1'h0;
      zin.alarm[1] <= 1'h1;
      cyc(3);
      check(alarm_led[1], 8'h00);
      zin.alarm[1] <= 1'h0;
      press(`ZAA_IN_CLR);
   endtask : t_master_off
   // A 24-hour zone alarms with master off; latching paths need clear
   task automatic t_latch_24h();
      @(posedge clk);
      cfg.zone_24h[0] <= 1'h1;
      cfg.ind_latch[0] <= 1'h1;
      cfg.snd_silence <= 1'h0;
      cfg.com_mode[0] <= zaa_pkg::ZAA_CM_LATCH;
      cfg.com_mode[1] <= zaa_pkg::ZAA_CM_NONLATCH;
      remote(3'h0, 1'h1);
      check(shunt_led[0], 8'h00);
      zin.alarm[0] <= 1'h1;
      cyc(3);
      check(alarm_led[0], 8'h01);
      check({sounder, com_out, ind_out[0]}, 8'h0F);
      press(`ZAA_IN_ACK);
      check(sounder, 8'h01);
      zin.alarm[0] <= 1'h0;
      cyc(3);
      check(ind_out[0], 8'h01);
      check(com_out, 8'h01);
      check(sounder, 8'h01);
      press(`ZAA_IN_CLR);
      check({sounder, com_out, ind_out[0]}, 8'h00);
      check(alarm_led[0], 8'h00);
   endtask : t_latch_24h
   // Master on: silence on acknowledge, re-sound on a second zone
   task automatic t_silence();
      @(posedge clk);
      cfg.snd_silence <= 1'h1;
      cfg.com_mode[1] <= zaa_pkg::ZAA_CM_AUDIBLE;
      cfg.com_mode[0] <= zaa_pkg::ZAA_CM_AUDIBLE;
      press(`ZAA_IN_MKEY);
      sw(`ZAA_IN_MKEY, 1'h1);
      cyc(12);
      zin.alarm[3] <= 1'h1;
      cyc(3);
      check({sounder, com_out, ind_out[3]}, 8'h0F);
      press(`ZAA_IN_ACK);
      check(sounder, 8'h00);
      check(com_out, 8'h00);
      zin.alarm[4] <= 1'h1;
      cyc(3);
      check(sounder, 8'h01);
      press(`ZAA_IN_ACK);
      zin.alarm[3] <= 1'h0;
      zin.alarm[4] <= 1'h0;
      cyc(3);
      check(ind_out[3], 8'h00);
      press(5);
      check(shunt_led[5], 8'h00);
      press(`ZAA_IN_CLR);
   endtask : t_silence
   // Remote shunt and the shunt-indicating common output
   task automatic t_remote();
      @(posedge clk);
      cfg.com_mode[1] <= zaa_pkg::ZAA_CM_SHUNT;
      cfg.com_mode[0] <= zaa_pkg::ZAA_CM_SHUNT;
      remote(3'h6, 1'h1);
      check(shunt_led[6], 8'h01);
      check(com_out, 8'h03);
      zin.alarm[6] <= 1'h1;
      cyc(3);
      check(alarm_led[6], 8'h00);
      zin.alarm[6] <= 1'h0;
      remote(3'h6, 1'h0);
      check({shunt_led[6], com_out}, 8'h00);
      sw(`ZAA_IN_MKEY, 1'h0);
      cyc(12);
   endtask : t_remote
   // Master off: buttons bypass, keys lock them, glitches do nothing
   task automatic t_keys();
      sw(5, 1'h1);
      cyc(2);
      sw(5, 1'h0);
      cyc(12);
      check(shunt_led[5], 8'h00);
      press(5);
      check(shunt_led[5], 8'h01);
      sw(`ZAA_IN_SMEM, 1'h1);
      cyc(12);
      press(5);
      remote(3'h5, 1'h0);
      check(shunt_led[5], 8'h01);
      sw(`ZAA_IN_SMEM, 1'h0);
      sw(`ZAA_IN_SDIS, 1'h1);
      cyc(12);
      press(2);
      check(shunt_led[2], 8'h00);
      remote(3'h2, 1'h1);
      check(shunt_led[2], 8'h01);
      sw(`ZAA_IN_SDIS, 1'h0);
      cyc(12);
      // Zone button acknowledges, then resets once the tamper is gone
      zin.tamper[7] <= 1'h1;
      cyc(3);
      check({trouble_led[7], alarm_led[7]}, 8'h03);
      press(7);
      check({sounder, shunt_led[7]}, 8'h00);
      zin.tamper[7] <= 1'h0;
      press(7);
      check(alarm_led[7], 8'h00);
   endtask : t_keys
   // Main sequence: reset two cycles, then every scenario in turn
   initial begin
      cyc(2);
      rst_n <= 1'h1;
      cyc(1);
      t_reset();
      t_master_off();
      t_latch_24h();
      t_silence();
      t_remote();
      t_keys();
      final_report();
   end
   // Watchdog well beyond the roughly 475 cycles the scenarios take
   initial begin
      #200000;
      fails++;
      final_report();
   end
endmodule : testbench
